/* File: dcr_defs.svh */
// Constants for the debug command register block: link offsets, field
// positions, command codes and synchroniser depth.
// Assumes it is included by bare name from every file that needs it.
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the debug link (7-bit address space)
// ----------------------------------------------------------------------
`define DCR_OFS_MASTER_CTL   7'h11
`define DCR_OFS_WR_UPPER     7'h13
`define DCR_OFS_WR_HIGH      7'h14
`define DCR_OFS_WR_LOW       7'h15
`define DCR_OFS_ACCESS_CMD   7'h16
`define DCR_OFS_BUS_CTL      7'h17

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DCR_MCTL_RESET_BIT   7
`define DCR_BUS_EN_BIT       7
`define DCR_BUS_FORCE_BIT    6
`define DCR_STAGE_RESET      8'h00
`define DCR_BUS_CTL_RESET    8'h00

// ----------------------------------------------------------------------
// Access command codes
// ----------------------------------------------------------------------
`define DCR_CMD_WRITE_BIT    7
`define DCR_CODE_LAST_GROUP  7'h05
`define DCR_CODE_SP          7'h06
`define DCR_CODE_PC          7'h07
`define DCR_CODE_SET_LONG    7'h08
`define DCR_CODE_CLR_LONG    7'h09
`define DCR_CODE_EXCHANGE    7'h0a
`define DCR_CODE_MEMORY      7'h0b

// ----------------------------------------------------------------------
// Link pin synchronisers
// ----------------------------------------------------------------------
`define DCR_SYNC_STAGES      2

`endif

/* File: dcr_pkg.sv */
// Types shared by the debug command register block.
// Assumes dcr_defs.svh is compiled alongside; holds no constants of its own.
package dcr_pkg;

  // Command sequencer states, Gray coded along idle-exec-memory-increment
  typedef enum logic [1:0] {
    DCR_IDLE  = 2'b00,
    DCR_EXEC  = 2'b01,
    DCR_MEM   = 2'b11,
    DCR_PCINC = 2'b10
  } dcr_state_t;

  // Processor register group presented on the core select port
  typedef enum logic [3:0] {
    DCR_G_BASE_AF  = 4'h0,
    DCR_G_BC       = 4'h1,
    DCR_G_DE       = 4'h2,
    DCR_G_HL       = 4'h3,
    DCR_G_IX       = 4'h4,
    DCR_G_IY       = 4'h5,
    DCR_G_SP_SHORT = 4'h6,
    DCR_G_SP_LONG  = 4'h7,
    DCR_G_PC       = 4'h8
  } dcr_group_t;

endpackage

/* File: dcr_link_rx.sv */
// Receiver for the two-wire debug link: frames write bytes into
// (address, data) strobes with address auto-increment.
// Assumes link clock and data are asynchronous pins; clk is far faster.
`timescale 1ns/100ps
`default_nettype none
`include "dcr_defs.svh"

module dcr_link_rx (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       link_clock_pin,
  input  wire logic       link_data_pin,
  output logic            wr_strobe,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);

  // --------------------------------------------------------------------
  // Pin synchronisers and edge history
  // --------------------------------------------------------------------
  logic [1:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  logic       clk_prev_reg;
  logic       dat_prev_reg;

  // Only stage 1 feeds edge logic; stage 0 is read by stage 1 alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync_reg <= 2'h3;  // Idle-high level, so release shows no false edge
      dat_sync_reg <= 2'h3;
      clk_prev_reg <= 1'b1;
      dat_prev_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], link_clock_pin};
      dat_sync_reg <= {dat_sync_reg[0], link_data_pin};
      clk_prev_reg <= clk_sync_reg[1];
      dat_prev_reg <= dat_sync_reg[1];
    end
  end

  logic clk_rise;
  logic frame_start;
  logic frame_stop;
  // Data moving while the link clock is high marks frame boundaries
  assign clk_rise    = clk_sync_reg[1] & ~clk_prev_reg;
  assign frame_start = clk_sync_reg[1] & clk_prev_reg & dat_prev_reg & ~dat_sync_reg[1];
  assign frame_stop  = clk_sync_reg[1] & clk_prev_reg & ~dat_prev_reg & dat_sync_reg[1];

  // --------------------------------------------------------------------
  // Byte assembly and address tracking
  // --------------------------------------------------------------------
  logic       in_frame_reg;
  logic       have_addr_reg;
  logic       write_ok_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [6:0] addr_reg;
  logic [7:0] byte_next;
  assign byte_next = {shift_reg[6:0], dat_sync_reg[1]};

  // First byte is address plus direction; later bytes are write data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_frame_reg  <= 1'b0;
      have_addr_reg <= 1'b0;
      write_ok_reg  <= 1'b0;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      addr_reg      <= 7'h00;
      wr_strobe     <= 1'b0;
      wr_addr       <= 7'h00;
      wr_data       <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (frame_start) begin
        in_frame_reg  <= 1'b1;
        have_addr_reg <= 1'b0;
        bit_cnt_reg   <= 3'h0;
      end else if (frame_stop) begin
        in_frame_reg <= 1'b0;
      end else if (in_frame_reg && clk_rise) begin
        shift_reg   <= byte_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          if (!have_addr_reg) begin
            have_addr_reg <= 1'b1;
            addr_reg      <= byte_next[7:1];
            write_ok_reg  <= ~byte_next[0];
          end else if (write_ok_reg) begin
            wr_strobe <= 1'b1;
            wr_addr   <= addr_reg;
            wr_data   <= byte_next;
            addr_reg  <= addr_reg + 7'h01;
          end
        end
      end
    end
  end

endmodule // dcr_link_rx
`default_nettype wire

/* File: dcr_top.sv */
// Write-only debug command registers behind the two-wire debug link,
// driving the processor register file, memory strobes and bus grant.
// Assumes core-side inputs are on clk; the bus request pin is asynchronous.
//
// What this block does
// - Master control bit 7 starts chip reset, self-clears when reset completes.
// - Master control write wakes the processor from halt or sleep.
// - Offsets 13h, 14h, 15h stage upper, high, low bytes of 24-bit value.
// - Narrower writes take their bits from the low end of the value.
// - Access command at 16h follows data bytes so one burst suffices.
// - Command write executes at once; reads fill read bytes, writes use staged.
// - Codes 00-05 read base/AF, BC, DE, HL, IX, IY into read bytes.
// - Codes 80-85 load the same groups from the staged bytes.
// - 06 reads, 86 writes stack pointer; long or short by address mode.
// - 07 reads, 87 writes the 24-bit program counter, byte for byte.
// - 08 sets, 09 clears the long address mode flag.
// - 0A swaps main AF, BC, DE, HL with their alternates.
// - 0B reads, 8B writes memory at program counter, then counter increments.
// - Bus control bit 7 clear: bus requests ignored, grant given only when bit 6 forces it.
// - Bus control bit 7 set: grant given once current operation ends.
// - Bus control bit 6 forces grant; clearing it releases the bus unless bit 7 is set and a request is held.
`timescale 1ns/100ps
`default_nettype none
`include "dcr_defs.svh"

module dcr_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        link_clock_pin,
  input  wire logic        link_data_pin,
  input  wire logic        core_reset_done,
  output logic             chip_reset_request,
  output logic             wake_request,
  output logic [3:0]       core_sel,
  output logic             core_wr_en,
  output logic [23:0]      core_wr_data,
  input  wire logic [23:0] core_rd_data,
  input  wire logic        long_address_mode,
  input  wire logic [7:0]  memory_base,
  output logic             adl_set,
  output logic             adl_clear,
  output logic             exchange_sets,
  output logic [23:0]      mem_addr,
  output logic             mem_rd_strobe,
  output logic             mem_wr_strobe,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic [7:0]       read_data_upper,
  output logic [7:0]       read_data_high,
  output logic [7:0]       read_data_low,
  output logic             busy,
  input  wire logic        bus_request_pin_n,
  output logic             bus_grant_pin_n
);

  // ----------------------------------------------------------------------
  // Link receiver
  // ----------------------------------------------------------------------
  logic       lk_strobe;
  logic [6:0] lk_addr;
  logic [7:0] lk_data;

  dcr_link_rx u_link_rx (
    .clk            (clk),
    .reset_n        (reset_n),
    .link_clock_pin (link_clock_pin),
    .link_data_pin  (link_data_pin),
    .wr_strobe      (lk_strobe),
    .wr_addr        (lk_addr),
    .wr_data        (lk_data)
  );

  logic wr_master;
  logic wr_cmd;
  logic wr_bus;
  // Address decode; unmapped offsets are dropped silently
  assign wr_master = lk_strobe && (lk_addr == `DCR_OFS_MASTER_CTL);
  assign wr_cmd    = lk_strobe && (lk_addr == `DCR_OFS_ACCESS_CMD);
  assign wr_bus    = lk_strobe && (lk_addr == `DCR_OFS_BUS_CTL);

  // ----------------------------------------------------------------------
  // Master control: chip reset and wake
  // ----------------------------------------------------------------------
  // Link write set wins over the completion clear so a new request is kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_reset_request <= 1'b0;
    end else if (wr_master && lk_data[`DCR_MCTL_RESET_BIT]) begin
      chip_reset_request <= 1'b1;
    end else if (core_reset_done) begin
      chip_reset_request <= 1'b0;
    end
  end

  // Any master control write pulses wake; harmless if core already runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wr_master;
    end
  end

  // ----------------------------------------------------------------------
  // Write data staging
  // ----------------------------------------------------------------------
  logic [7:0]  wr_upper_reg;
  logic [7:0]  wr_high_reg;
  logic [7:0]  wr_low_reg;
  logic [23:0] staged_value;
  assign staged_value = {wr_upper_reg, wr_high_reg, wr_low_reg};

  // Staging bytes may be rewritten while a command runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_upper_reg <= `DCR_STAGE_RESET;
      wr_high_reg  <= `DCR_STAGE_RESET;
      wr_low_reg   <= `DCR_STAGE_RESET;
    end else if (lk_strobe) begin
      if (lk_addr == `DCR_OFS_WR_UPPER) wr_upper_reg <= lk_data;
      if (lk_addr == `DCR_OFS_WR_HIGH)  wr_high_reg  <= lk_data;
      if (lk_addr == `DCR_OFS_WR_LOW)   wr_low_reg   <= lk_data;
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  dcr_pkg::dcr_state_t state_reg;
  logic [7:0]          cmd_reg;
  logic [6:0]          code;
  logic                is_write;
  logic                is_group;
  logic                is_memory;
  logic                is_special;
  assign code       = cmd_reg[6:0];
  assign is_write   = cmd_reg[`DCR_CMD_WRITE_BIT];
  assign is_group   = (code <= `DCR_CODE_PC);
  assign is_memory  = (code == `DCR_CODE_MEMORY);
  // Mode and exchange codes exist only without the write bit
  assign is_special = !is_write && (code >= `DCR_CODE_SET_LONG) && (code <= `DCR_CODE_EXCHANGE);

  dcr_pkg::dcr_group_t cmd_group;
  // Map the code onto a register group; stack pointer follows mode flag
  always_comb begin
    if (code <= `DCR_CODE_LAST_GROUP) begin
      cmd_group = dcr_pkg::dcr_group_t'(code[3:0]);
    end else if (code == `DCR_CODE_SP) begin
      cmd_group = long_address_mode ? dcr_pkg::DCR_G_SP_LONG : dcr_pkg::DCR_G_SP_SHORT;
    end else begin
      cmd_group = dcr_pkg::DCR_G_PC;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  logic [23:0] pc_inc_reg;
  logic        mem_is_read_reg;

  // Commands arriving while busy are dropped; link bytes are far slower
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= dcr_pkg::DCR_IDLE;
    end else begin
      case (state_reg)
        dcr_pkg::DCR_IDLE: begin
          if (wr_cmd) state_reg <= dcr_pkg::DCR_EXEC;
        end
        dcr_pkg::DCR_EXEC: begin
          state_reg <= is_memory ? dcr_pkg::DCR_MEM : dcr_pkg::DCR_IDLE;
        end
        dcr_pkg::DCR_MEM: begin
          state_reg <= dcr_pkg::DCR_PCINC;
        end
        dcr_pkg::DCR_PCINC: begin
          state_reg <= dcr_pkg::DCR_IDLE;
        end
        default: begin
          state_reg <= dcr_pkg::DCR_IDLE;
        end
      endcase
    end
  end

  // Command and write operand latched together when the command is taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg      <= 8'h00;
      core_wr_data <= 24'h000000;
    end else if (state_reg == dcr_pkg::DCR_IDLE && wr_cmd) begin
      cmd_reg      <= lk_data;
      core_wr_data <= staged_value;
    end else if (state_reg == dcr_pkg::DCR_MEM) begin
      core_wr_data <= pc_inc_reg;
    end
  end

  // Memory address formed from the counter; short mode uses the base byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr        <= 24'h000000;
      pc_inc_reg      <= 24'h000000;
      mem_is_read_reg <= 1'b0;
      mem_wdata       <= 8'h00;
    end else if (state_reg == dcr_pkg::DCR_EXEC && is_memory) begin
      mem_addr        <= long_address_mode ? core_rd_data : {memory_base, core_rd_data[15:0]};
      pc_inc_reg      <= core_rd_data + 24'h000001;
      mem_is_read_reg <= !is_write;
      mem_wdata       <= wr_low_reg;
    end
  end

  // Read results; reserved codes leave these bytes untouched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data_upper <= 8'h00;
      read_data_high  <= 8'h00;
      read_data_low   <= 8'h00;
    end else if (state_reg == dcr_pkg::DCR_EXEC && !is_write && is_group) begin
      read_data_upper <= core_rd_data[23:16];
      read_data_high  <= core_rd_data[15:8];
      read_data_low   <= core_rd_data[7:0];
    end else if (state_reg == dcr_pkg::DCR_PCINC && mem_is_read_reg) begin
      read_data_low <= mem_rdata;
    end
  end

  // Core strobes are single-cycle and decoded from the sequencer state
  always_comb begin
    core_sel      = dcr_pkg::DCR_G_PC;
    core_wr_en    = 1'b0;
    adl_set       = 1'b0;
    adl_clear     = 1'b0;
    exchange_sets = 1'b0;
    mem_rd_strobe = 1'b0;
    mem_wr_strobe = 1'b0;
    case (state_reg)
      dcr_pkg::DCR_EXEC: begin
        core_sel      = is_group ? cmd_group : dcr_pkg::DCR_G_PC;
        core_wr_en    = is_write && is_group;
        adl_set       = is_special && (code == `DCR_CODE_SET_LONG);
        adl_clear     = is_special && (code == `DCR_CODE_CLR_LONG);
        exchange_sets = is_special && (code == `DCR_CODE_EXCHANGE);
      end
      dcr_pkg::DCR_MEM: begin
        mem_rd_strobe = mem_is_read_reg;
        mem_wr_strobe = !mem_is_read_reg;
      end
      dcr_pkg::DCR_PCINC: begin
        core_wr_en = 1'b1;
      end
      default: begin
        core_sel = dcr_pkg::DCR_G_PC;
      end
    endcase
  end

  assign busy = (state_reg != dcr_pkg::DCR_IDLE);

  // ----------------------------------------------------------------------
  // Bus grant control
  // ----------------------------------------------------------------------
  logic       grant_enable_reg;
  logic       grant_force_reg;
  logic [1:0] req_sync_reg;
  logic       grant_reg;
  logic       grant_next;
  localparam logic [7:0] bus_ctl_rst = `DCR_BUS_CTL_RESET;

  // Reserved bits are ignored; writes are only expected in debug mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_enable_reg <= bus_ctl_rst[`DCR_BUS_EN_BIT];
      grant_force_reg  <= bus_ctl_rst[`DCR_BUS_FORCE_BIT];
    end else if (wr_bus) begin
      grant_enable_reg <= lk_data[`DCR_BUS_EN_BIT];
      grant_force_reg  <= lk_data[`DCR_BUS_FORCE_BIT];
    end
  end

  // Request pin is asynchronous and active low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_sync_reg <= 2'h0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], ~bus_request_pin_n};
    end
  end

  // A held grant is kept while the request stays; a new one waits for idle
  assign grant_next = grant_force_reg ||
                      (grant_enable_reg && req_sync_reg[1] &&
                       (grant_reg || state_reg == dcr_pkg::DCR_IDLE));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_reg <= 1'b0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  assign bus_grant_pin_n = ~grant_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  reset_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_master && lk_data[`DCR_MCTL_RESET_BIT] |=> chip_reset_request)
    else $error("chip reset request not raised");

  reset_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    core_reset_done && !wr_master |=> !chip_reset_request)
    else $error("chip reset request not cleared");

  wake_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_master |=> wake_request ##1 !wake_request)
    else $error("wake request not a single pulse");

  operand_take_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_IDLE && wr_cmd |=> core_wr_data == $past(staged_value) && busy)
    else $error("write operand not taken from staged value");

  group_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && !is_write && is_group
      |=> {read_data_upper, read_data_high, read_data_low} == $past(core_rd_data))
    else $error("read bytes do not hold selected group");

  group_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && is_write && code <= `DCR_CODE_LAST_GROUP
      |-> core_wr_en && core_sel == code[3:0])
    else $error("group write not issued");

  stack_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && code == `DCR_CODE_SP
      |-> core_sel == (long_address_mode ? dcr_pkg::DCR_G_SP_LONG : dcr_pkg::DCR_G_SP_SHORT))
    else $error("wrong stack pointer selected");

  mode_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && cmd_reg == 8'h08 |-> adl_set && !adl_clear)
    else $error("mode set not issued");

  // Write-back must be the counter read two cycles earlier plus one
  mem_walk_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && is_memory
      |=> (mem_rd_strobe != mem_wr_strobe) ##1 (core_wr_en && core_sel == dcr_pkg::DCR_G_PC
          && core_wr_data == $past(core_rd_data, 2) + 24'h000001)
      ##1 !busy)
    else $error("memory access sequence broken");

  reserved_nop_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == dcr_pkg::DCR_EXEC && !is_group && !is_memory && !is_special
      |-> !core_wr_en && !adl_set && !adl_clear && !exchange_sets ##1 !busy && $stable(read_data_low))
    else $error("reserved code had an effect");

  grant_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !grant_enable_reg && !grant_force_reg |=> bus_grant_pin_n)
    else $error("grant given while disabled");

  grant_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    !grant_force_reg && busy && bus_grant_pin_n |=> bus_grant_pin_n)
    else $error("grant given during an operation");

  grant_force_a: assert property (@(posedge clk) disable iff (!reset_n)
    grant_force_reg |=> !bus_grant_pin_n)
    else $error("forced grant not driven");

endmodule // dcr_top
`default_nettype wire

/* File: dcr_link_master.sv */
// Debug link master model: frames write bytes onto the two-wire link.
// Assumes the bench calls send; link clock idles high, 160 ns period.
`timescale 1ns/100ps
`default_nettype none
module dcr_link_master (
  output logic link_clock_pin,
  output logic link_data_pin
);
  // Both lines idle high between frames
  initial begin
    link_clock_pin = 1'b1;
    link_data_pin = 1'b1;
  end
  // Address byte with write flag, then n data bytes left-aligned in d
  // Bit data moves only while the clock is low, so no false start or stop
  task automatic send(input logic [6:0] a, input logic [31:0] d, input int n);
    logic [39:0] f;
    f = {a, 1'b0, d};
    link_data_pin <= 1'b0;
    #80;
    for (int i = 39; i > 31 - 8 * n; i--) begin
      link_clock_pin <= 1'b0;
      #40;
      link_data_pin <= f[i];
      #40;
      link_clock_pin <= 1'b1;
      #80;
    end
    link_clock_pin <= 1'b0;
    #40;
    link_data_pin <= 1'b0;
    #40;
    link_clock_pin <= 1'b1;
    #80;
    link_data_pin <= 1'b1;
    #80;
  endtask
endmodule // dcr_link_master
`default_nettype wire

/* File: dcr_top_tb.sv */
// Self-checking bench for dcr_top with a core register file model.
// Assumes dcr_link_master drives the two link pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module dcr_top_tb;
  logic clk, reset_n, core_reset_done, long_address_mode, bus_request_pin_n;
  logic link_clock_pin, link_data_pin, chip_reset_request, wake_request, core_wr_en;
  logic adl_set, adl_clear, exchange_sets, mem_rd_strobe, mem_wr_strobe, busy, bus_grant_pin_n;
  logic [3:0] core_sel;
  logic [23:0] core_wr_data, core_rd_data, mem_addr, v, pc, ma;
  logic [23:0] rf [0:8];
  logic [7:0] memory_base, mem_wdata, mem_rdata, read_data_upper, read_data_high, read_data_low, mw;
  int bad_count, samples_checked, wk, xc, seed, g, bz, mr;
  dcr_top uut (.clk, .reset_n, .link_clock_pin, .link_data_pin, .core_reset_done, .chip_reset_request,
    .wake_request, .core_sel, .core_wr_en, .core_wr_data, .core_rd_data, .long_address_mode, .memory_base,
    .adl_set, .adl_clear, .exchange_sets, .mem_addr, .mem_rd_strobe, .mem_wr_strobe, .mem_wdata, .mem_rdata,
    .read_data_upper, .read_data_high, .read_data_low, .busy, .bus_request_pin_n, .bus_grant_pin_n);
  dcr_link_master lm (.link_clock_pin, .link_data_pin);
  assign core_rd_data = rf[core_sel];
  // Core model: register file, mode flag, pulse counts, memory capture
  always @(posedge clk) begin
    if (core_wr_en) rf[core_sel] <= core_wr_data;
    if (adl_set) long_address_mode <= 1'b1;
    if (adl_clear) long_address_mode <= 1'b0;
    if (exchange_sets) xc <= xc + 1;
    if (wake_request) wk <= wk + 1;
    if (mem_wr_strobe | mem_rd_strobe) ma <= mem_addr;
    if (mem_wr_strobe) mw <= mem_wdata;
    if (mem_rd_strobe) mr <= mr + 1;
    if (busy) bz <= bz + 1;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Frame plus settling; a command finishes well inside ten cycles
  task automatic cmd(input logic [6:0] a, input logic [31:0] d, input int n);
    lm.send(a, d, n);
    repeat (10) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: the full run needs well under half of this span
  initial begin
    #300000;
    bad_count++;
    stop_test;
  end
  initial begin
    seed = 32'hba0db33f;
    {reset_n, core_reset_done, long_address_mode, memory_base, mem_rdata} = '0;
    {bus_request_pin_n, bad_count, samples_checked, wk, xc, bz, mr} = '0;
    bus_request_pin_n = 1'b1;
    for (int i = 0; i < 9; i++) rf[i] = 24'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    memory_base <= $random(seed);
    cmd(7'h11, {8'h80, 24'h0}, 1);
    `CHK("chip reset", 1'b1, chip_reset_request)
    `CHK("wake", 1, wk)
    @(posedge clk) core_reset_done <= 1'b1;
    @(posedge clk) core_reset_done <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("chip reset", 1'b0, chip_reset_request)
    // Every register group except long stack pointer: staged burst write, then read back
    for (int c = 0; c < 8; c++) begin
      v = $random(seed);
      g = c < 6 ? c : (c == 6 ? 6 + long_address_mode : 8);
      cmd(7'h13, {v, 8'h80 | c[7:0]}, 4);
      `CHK("group", v, rf[g])
      cmd(7'h16, {c[7:0], 24'h0}, 1);
      `CHK("read", v, {read_data_upper, read_data_high, read_data_low})
    end
    pc = v;
    cmd(7'h13, {~v, 8'h88}, 4);
    `CHK("reserved", v, {read_data_upper, read_data_high, read_data_low})
    `CHK("reserved pc", v, rf[8])
    cmd(7'h16, {8'h08, 24'h0}, 1);
    `CHK("long mode", 1'b1, long_address_mode)
    cmd(7'h13, {v, 8'h86}, 4);
    `CHK("sp long", v, rf[7])
    mem_rdata <= $random(seed);
    cmd(7'h16, {8'h0b, 24'h0}, 1);
    `CHK("mem addr", pc, ma)
    `CHK("mem read", mem_rdata, read_data_low)
    pc = pc + 1;
    `CHK("pc", pc, rf[8])
    cmd(7'h16, {8'h09, 24'h0}, 1);
    `CHK("long mode", 1'b0, long_address_mode)
    bz = 0;
    cmd(7'h13, {v, 8'h8b}, 4);
    `CHK("mem addr", {memory_base, pc[15:0]}, ma)
    `CHK("mem byte", v[7:0], mw)
    `CHK("pc", pc + 24'h1, rf[8])
    `CHK("mem busy", 3, bz)
    `CHK("mem read strobes", 1, mr)
    bz = 0;
    cmd(7'h16, {8'h0a, 24'h0}, 1);
    `CHK("exchange", 1, xc)
    `CHK("busy", 1, bz)
    bus_request_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("grant off", 1'b1, bus_grant_pin_n)
    cmd(7'h17, {8'h80, 24'h0}, 1);
    `CHK("grant on", 1'b0, bus_grant_pin_n)
    bus_request_pin_n <= 1'b1;
    cmd(7'h17, {8'h40, 24'h0}, 1);
    `CHK("grant force", 1'b0, bus_grant_pin_n)
    cmd(7'h17, {8'h00, 24'h0}, 1);
    `CHK("grant free", 1'b1, bus_grant_pin_n)
    stop_test;
  end
endmodule // dcr_top_tb
`default_nettype wire
